// [rtl/pmc_power_mode.sv]
// module power-mode controller with wishbone register access
// Notes on behaviour
// [R1] reset, low-power or force bit mean low power
// [R2] transmitters disabled whenever in low power
// [R3] high power only when all three clear
// [R4] high to low completes within 200 us
// [R5] low power keeps functions to lowest class
// [R6] advertised class readable at any time
// [R7] high power functions capped by advertised class
// [R8] highest class reports its maximum power value
// [R9] host breaker gating on presence is host side
// [R10] force bit returns to default on reset
// [R11] reset input overrides every other control
// [R12] two-stage synchronise reset and low-power inputs
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
module pmc_power_mode #(
    parameter logic [2:0] ADV_CLASS = 3'h7, // advertised class code
    parameter logic [15:0] MAX_POWER = 16'h00C8, // maximum power, tenths of a watt
    parameter logic FORCE_DEFAULT = 1'b0, // preprogrammed force bit
    parameter int SETTLE = pmc_pkg::SETTLE_CYCLES // cycles to complete shutdown
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // host sideband, active low
    input wire logic moduleResetIn_n,
    input wire logic moduleLowpowerIn_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // power and transmitter controls
    output logic highPower,
    output logic txEnable,
    output logic inReset,
    output logic [pmc_pkg::FUNC_W-1:0] funcEnable,
    output logic [pmc_pkg::CLASS_W-1:0] activeClass
);
    import pmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // class budget: highest class a function mask may reach
    function automatic logic [CLASS_W-1:0] maskClass(input logic [FUNC_W-1:0] m);
        logic [CLASS_W-1:0] c;
        c = CLASS_LOWEST;
        for (int i = 0; i < FUNC_W; i++) begin
            if (m[i]) begin
                c = CLASS_W'(i);
            end
        end
        return c;
    endfunction : maskClass

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] rstSync_reg; // stage 0 feeds stage 1 only
    logic [1:0] rstSync_next;
    logic [1:0] lpwSync_reg;
    logic [1:0] lpwSync_next;
    logic rstAsserted; // synchronised reset request
    logic lpwAsserted; // synchronised low-power request

    // shift both inputs two stages
    always_comb begin
        rstSync_next = {rstSync_reg[0], moduleResetIn_n}; // R12
        lpwSync_next = {lpwSync_reg[0], moduleLowpowerIn_n}; // R12
    end

    // reset as asserted: low power from the start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'h0;
            lpwSync_reg <= 2'h0;
        end else if (clkEn) begin
            rstSync_reg <= rstSync_next;
            lpwSync_reg <= lpwSync_next;
        end
    end

    assign rstAsserted = !rstSync_reg[1];
    assign lpwAsserted = !lpwSync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // registers written by software
    logic force_reg; // force-low-power bit
    logic force_next;
    logic txSw_reg; // software transmitter enable
    logic txSw_next;
    logic [FUNC_W-1:0] func_reg; // requested functions
    logic [FUNC_W-1:0] func_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic ack_reg;
    logic ack_next;
    logic busReq; // request in flight, not yet acked
    logic wrHit; // write takes effect this edge
    pmc_state_type state_reg;
    pmc_state_type state_next;

    assign busReq = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wrHit = busReq && wb_we_i;

    // register writes, read mux and single-cycle ack
    always_comb begin
        force_next = force_reg;
        txSw_next = txSw_reg;
        func_next = func_reg;
        rdat_next = rdat_reg;
        ack_next = busReq;
        if (wrHit && wb_adr_i == CTRL_OFF) begin
            if (wb_sel_i[0]) begin
                force_next = wb_dat_i[FORCE_BIT];
                txSw_next = wb_dat_i[TXEN_BIT];
            end
            if (wb_sel_i[1]) begin
                func_next = wb_dat_i[FUNC_LSB +: FUNC_W];
            end
        end
        if (rstAsserted) begin
            force_next = FORCE_DEFAULT; // R10 R11
        end
        if (busReq && !wb_we_i) begin
            rdat_next = ZERO_WORD; // unmapped reads zero
            unique case (wb_adr_i)
                CTRL_OFF: begin
                    rdat_next[FORCE_BIT] = force_reg;
                    rdat_next[TXEN_BIT] = txSw_reg;
                    rdat_next[FUNC_LSB +: FUNC_W] = func_reg;
                end
                STAT_OFF: begin
                    rdat_next[ST_HIGH_BIT] = highPower;
                    rdat_next[ST_TXON_BIT] = txEnable;
                    rdat_next[ST_RST_BIT] = rstAsserted;
                    rdat_next[ST_LPW_BIT] = lpwAsserted;
                    rdat_next[ST_FORCE_BIT] = force_reg;
                    rdat_next[ST_STATE_LSB +: 2] = state_reg;
                end
                CLASS_OFF: begin
                    rdat_next[CLASS_W-1:0] = ADV_CLASS; // R6
                end
                MAXPWR_OFF: begin
                    if (ADV_CLASS == CLASS_HIGHEST) begin
                        rdat_next[MAXPWR_W-1:0] = MAX_POWER; // R8
                    end
                end
                default: begin
                    rdat_next = ZERO_WORD;
                end
            endcase
        end
    end

    // software register state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_reg <= FORCE_DEFAULT; // R10
            txSw_reg <= 1'b1;
            func_reg <= '0;
            rdat_reg <= ZERO_WORD;
            ack_reg <= 1'b0;
        end else if (clkEn) begin
            force_reg <= force_next;
            txSw_reg <= txSw_next;
            func_reg <= func_next;
            rdat_reg <= rdat_next;
            ack_reg <= ack_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power mode state machine
    logic goLow; // any low-power cause
    logic [15:0] settle_reg;
    logic [15:0] settle_next;
    logic highPower_reg;
    logic highPower_next;
    logic txEnable_reg;
    logic txEnable_next;
    logic inReset_reg;
    logic inReset_next;
    logic [FUNC_W-1:0] funcEn_reg;
    logic [FUNC_W-1:0] funcEn_next;
    logic [CLASS_W-1:0] actClass_reg;
    logic [CLASS_W-1:0] actClass_next;
    logic [FUNC_W-1:0] allowed; // functions fitting the advertised class

    assign goLow = rstAsserted || lpwAsserted || force_reg; // R1

    // cap requested functions at advertised class
    always_comb begin
        allowed = '0;
        for (int i = 0; i < FUNC_W; i++) begin
            allowed[i] = func_reg[i] && (CLASS_W'(i) <= ADV_CLASS); // R7
        end
    end

    // next state and outputs
    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        unique case (state_reg)
            PMC_LOW: begin
                if (!goLow) begin
                    state_next = PMC_RAMP; // R3
                end
            end
            PMC_RAMP: begin
                state_next = goLow ? PMC_LOW : PMC_HIGH; // R3
            end
            PMC_HIGH: begin
                if (goLow) begin
                    state_next = PMC_FALL; // R4
                    settle_next = 16'(SETTLE);
                end
            end
            PMC_FALL: begin
                if (settle_reg <= 16'h0001) begin
                    state_next = PMC_LOW; // R4
                end else begin
                    settle_next = settle_reg - 16'h0001;
                end
            end
        endcase
        highPower_next = (state_next == PMC_HIGH);
        inReset_next = rstAsserted; // R11
        // transmitters and functions only in high power, dropped at once
        txEnable_next = highPower_next && !goLow && txSw_reg; // R2 R11
        funcEn_next = (highPower_next && !goLow) ? allowed : '0; // R5 R7
        actClass_next = (highPower_next && !goLow) ? maskClass(allowed) : CLASS_LOWEST; // R5
    end

    // mode registers, low power at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= PMC_LOW;
            settle_reg <= 16'h0000;
            highPower_reg <= 1'b0;
            txEnable_reg <= 1'b0;
            inReset_reg <= 1'b1;
            funcEn_reg <= '0;
            actClass_reg <= CLASS_LOWEST;
        end else if (clkEn) begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            highPower_reg <= highPower_next;
            txEnable_reg <= txEnable_next;
            inReset_reg <= inReset_next;
            funcEn_reg <= funcEn_next;
            actClass_reg <= actClass_next;
        end
    end

    assign highPower = highPower_reg;
    assign txEnable = txEnable_reg;
    assign inReset = inReset_reg;
    assign funcEnable = funcEn_reg;
    assign activeClass = actClass_reg;
    assign wb_dat_o = rdat_reg;
    assign wb_ack_o = ack_reg;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_lowCause;
        clkEn && (rstAsserted || lpwAsserted || force_reg);
    endsequence

    property p_lowNoTx; // R2
        @(posedge clk) disable iff (!rst_n)
        !highPower |-> !txEnable;
    endproperty
    a_lowNoTx: assert property (p_lowNoTx) else $error("tx on in low power"); // R2

    property p_causeDrops; // R1
        @(posedge clk) disable iff (!rst_n)
        s_lowCause |=> !txEnable && funcEnable == '0;
    endproperty
    a_causeDrops: assert property (p_causeDrops) else $error("low cause ignored"); // R1

    property p_highNeedsClear; // R3
        @(posedge clk) disable iff (!rst_n)
        $rose(highPower) |-> $past(!goLow);
    endproperty
    a_highNeedsClear: assert property (p_highNeedsClear) else $error("high with cause"); // R3

    property p_fallDeadline; // R4
        @(posedge clk) disable iff (!rst_n)
        (clkEn && highPower && goLow) |-> ##[1:40] !highPower;
    endproperty
    a_fallDeadline: assert property (p_fallDeadline) else $error("late drop"); // R4

    property p_lowClass; // R5
        @(posedge clk) disable iff (!rst_n)
        !highPower |-> activeClass == CLASS_LOWEST;
    endproperty
    a_lowClass: assert property (p_lowClass) else $error("class above lowest"); // R5

    property p_capClass; // R7
        @(posedge clk) disable iff (!rst_n)
        activeClass <= ADV_CLASS;
    endproperty
    a_capClass: assert property (p_capClass) else $error("class over advert"); // R7

    property p_forceRevert; // R10
        @(posedge clk) disable iff (!rst_n)
        (clkEn && rstAsserted) |=> force_reg == FORCE_DEFAULT;
    endproperty
    a_forceRevert: assert property (p_forceRevert) else $error("force kept"); // R10

    property p_resetOverride; // R11
        @(posedge clk) disable iff (!rst_n)
        (clkEn && rstAsserted) |=> inReset && !txEnable;
    endproperty
    a_resetOverride: assert property (p_resetOverride) else $error("reset ignored"); // R11

    property p_syncDelay; // R12
        @(posedge clk) disable iff (!rst_n)
        (clkEn ##1 clkEn) |=> rstSync_reg[1] == $past(moduleResetIn_n, 2);
    endproperty
    a_syncDelay: assert property (p_syncDelay) else $error("sync depth wrong"); // R12

    property p_classRead; // R6
        @(posedge clk) disable iff (!rst_n)
        (clkEn && busReq && !wb_we_i && wb_adr_i == CLASS_OFF) |=> wb_dat_o[2:0] == ADV_CLASS;
    endproperty
    a_classRead: assert property (p_classRead) else $error("class read wrong"); // R6

    property p_maxPowerRead; // R8
        @(posedge clk) disable iff (!rst_n)
        (clkEn && busReq && !wb_we_i && wb_adr_i == MAXPWR_OFF) |=>
            wb_dat_o[MAXPWR_W-1:0] == (ADV_CLASS == CLASS_HIGHEST ? MAX_POWER : 16'h0000);
    endproperty
    a_maxPowerRead: assert property (p_maxPowerRead) else $error("max power read wrong"); // R8
endmodule : pmc_power_mode

// [rtl/pmc_pkg.sv]
// package: constants, register map and types for the module power-mode controller
package pmc_pkg;
    // wishbone register word offsets (byte addresses)
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] CLASS_OFF = 8'h08;
    localparam logic [7:0] MAXPWR_OFF = 8'h0C;
    // control register field positions
    localparam int FORCE_BIT = 0;
    localparam int TXEN_BIT = 1;
    localparam int FUNC_LSB = 8;
    // status register field positions
    localparam int ST_HIGH_BIT = 0;
    localparam int ST_TXON_BIT = 1;
    localparam int ST_RST_BIT = 2;
    localparam int ST_LPW_BIT = 3;
    localparam int ST_FORCE_BIT = 4;
    localparam int ST_STATE_LSB = 8;
    // widths
    localparam int CLASS_W = 3;
    localparam int FUNC_W = 8;
    localparam int MAXPWR_W = 16;
    // power classes: code 0 is the lowest class, code 7 the highest
    localparam logic [2:0] CLASS_LOWEST = 3'h0;
    localparam logic [2:0] CLASS_HIGHEST = 3'h7;
    localparam int NUM_CLASSES = 8;
    // mode change deadline
    localparam int HPLP_US = 200;
    localparam int CLK_MHZ = 50;
    localparam int HPLP_CYCLES = HPLP_US * CLK_MHZ;
    // shutdown settle count, well under the deadline
    localparam int SETTLE_CYCLES = 16;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // mode states, gray along low -> ramp -> high -> fall -> low
    typedef enum logic [1:0] {
        PMC_LOW = 2'b00,
        PMC_RAMP = 2'b01,
        PMC_HIGH = 2'b11,
        PMC_FALL = 2'b10
    } pmc_state_type;
endpackage : pmc_pkg

// [test/pmc_host_model.sv]
// host board model driving the reset and low-power sideband pins
`timescale 1ns/100ps
module pmc_host_model (
    // clock of the host logic
    input wire logic clk,
    // requests from the bench, active high
    input wire logic rstReq,
    input wire logic lpReq,
    // sideband pins towards the module, active low
    output logic moduleResetIn_n,
    output logic moduleLowpowerIn_n
);
    // module assumed fully seated, supply breaker closed before any request
    initial begin
        moduleResetIn_n = 1'b0;
        moduleLowpowerIn_n = 1'b0;
    end
    // pins change just after the host edge, which in the bench is also the edge the module samples them on
    always @(posedge clk) begin
        moduleResetIn_n <= ~rstReq;
        moduleLowpowerIn_n <= ~lpReq;
    end
endmodule : pmc_host_model

// [test/pmc_power_mode_tb.sv]
// self-checking bench for the power-mode controller
`timescale 1ns/100ps
module pmc_power_mode_tb;
    import pmc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic clk = 1'b0, rst_n = 1'b0, rstReq = 1'b1, lpReq = 1'b1, clkEn = 1'b1;
    logic [3:0] wbSel = 4'hF, laneSel = 4'hF;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0, wbDatR, rd;
    logic wbAck, highPower, txEnable, inReset, rstPin_n, lpPin_n;
    logic [FUNC_W-1:0] funcEnable;
    logic [CLASS_W-1:0] activeClass;
    int num_errors = 0, cmp_count = 0, cyc = 0, n;
    ////////////////////////////////////////////////////////////////////////
    pmc_host_model u_host (.clk(clk), .rstReq(rstReq), .lpReq(lpReq),
        .moduleResetIn_n(rstPin_n), .moduleLowpowerIn_n(lpPin_n));
    pmc_power_mode #(.ADV_CLASS(3'h5), .SETTLE(2)) u_dut (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .moduleResetIn_n(rstPin_n), .moduleLowpowerIn_n(lpPin_n),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .highPower(highPower), .txEnable(txEnable), .inReset(inReset),
        .funcEnable(funcEnable), .activeClass(activeClass));
    ////////////////////////////////////////////////////////////////////////
    // 50 MHz clock and cycle ceiling
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk
    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        wbSel <= laneSel;
        do begin
            @(posedge clk);
            k = k + 1;
        end while (wbAck !== 1'b1 && k < 50);
        rd = wbDatR;
        chk({31'h0, wbAck}, 32'h1, "bus ack");
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask : wb
    // cycles until highPower reaches a level, bounded
    task automatic wait_hp(input logic lvl);
        n = 0;
        while (highPower !== lvl && n < 400) begin
            @(posedge clk);
            n = n + 1;
        end
        chk({31'h0, highPower}, {31'h0, lvl}, "highPower level");
    endtask : wait_hp
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        chk({29'h0, highPower, txEnable, inReset}, 32'h1, "held in reset");
        wb(1'b0, CLASS_OFF, 32'h0);
        chk(rd, 32'h5, "class readable");
        wb(1'b0, MAXPWR_OFF, 32'h0);
        chk(rd, ZERO_WORD, "max power below top class");
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, ZERO_WORD, "unmapped read");
        wb(1'b0, CTRL_OFF, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h2, "ctrl reset value");
        $display("test reset_values done");
    endtask : t_reset_values
    task automatic t_power_up();
        rstReq <= 1'b0;
        repeat (10) @(posedge clk);
        chk({31'h0, highPower}, 32'h0, "low power pin still held");
        lpReq <= 1'b0;
        wait_hp(1'b1);
        chk({31'h0, txEnable}, 32'h1, "tx on in high power");
        wb(1'b1, CTRL_OFF, 32'h0000_FF02);
        repeat (3) @(posedge clk);
        chk({24'h0, funcEnable}, 32'h3F, "functions capped");
        chk({29'h0, activeClass}, 32'h5, "active class capped");
        laneSel = 4'h1;
        wb(1'b1, CTRL_OFF, 32'h0000_0002);
        wb(1'b0, CTRL_OFF, 32'h0);
        laneSel = 4'hF;
        chk({24'h0, rd[15:8]}, 32'hFF, "mask kept outside byte lane");
        $display("test power_up done");
    endtask : t_power_up
    task automatic t_low_power();
        lpReq <= 1'b1;
        wait_hp(1'b0);
        chk({31'h0, n <= HPLP_CYCLES}, 32'h1, "deadline");
        chk({31'h0, txEnable}, 32'h0, "tx off in low power");
        chk({24'h0, funcEnable}, 32'h0, "lowest class only");
        chk({29'h0, activeClass}, {29'h0, CLASS_LOWEST}, "class lowest in low power");
        lpReq <= 1'b0;
        wait_hp(1'b1);
        $display("test low_power done");
    endtask : t_low_power
    task automatic t_force();
        wb(1'b1, CTRL_OFF, 32'h0000_FF03);
        wait_hp(1'b0);
        chk({31'h0, txEnable}, 32'h0, "tx off when forced");
        wb(1'b0, STAT_OFF, 32'h0);
        chk({31'h0, rd[ST_FORCE_BIT]}, 32'h1, "force status");
        wb(1'b1, CTRL_OFF, 32'h0000_FF02);
        wait_hp(1'b1);
        $display("test force done");
    endtask : t_force
    task automatic t_freeze();
        clkEn <= 1'b0;
        lpReq <= 1'b1;
        repeat (8) @(posedge clk);
        chk({31'h0, highPower}, 32'h1, "state frozen while disabled");
        clkEn <= 1'b1;
        wait_hp(1'b0);
        lpReq <= 1'b0;
        wait_hp(1'b1);
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_reset_override();
        rstReq <= 1'b1;
        repeat (8) @(posedge clk);
        chk({29'h0, inReset, highPower, txEnable}, 32'h4, "reset from high power");
        rstReq <= 1'b0;
        wait_hp(1'b1);
        wb(1'b1, CTRL_OFF, 32'h0000_FF03);
        rstReq <= 1'b1;
        repeat (8) @(posedge clk);
        chk({29'h0, inReset, highPower, txEnable}, 32'h4, "reset overrides");
        wb(1'b0, CTRL_OFF, 32'h0);
        chk({31'h0, rd[FORCE_BIT]}, 32'h0, "force reverted");
        rstReq <= 1'b0;
        wait_hp(1'b1);
        $display("test reset_override done");
    endtask : t_reset_override
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_power_up();
        t_low_power();
        t_force();
        t_freeze();
        t_reset_override();
        give_verdict();
    end
endmodule : pmc_power_mode_tb
